// >>> sscc_pkg.sv
// sscc_pkg: register map, field codes and error codes for the settings checker.
// assumes: AXI4-Lite slave with 32-bit data; byte addresses are word aligned.
package sscc_pkg;
	localparam logic [7:0] ADDR_BW = 8'h00;
	localparam logic [7:0] ADDR_BUF_SIZE = 8'h04;
	localparam logic [7:0] ADDR_MTYPE = 8'h08;
	localparam logic [7:0] ADDR_TABLE_SEL = 8'h0C;
	localparam logic [7:0] ADDR_TABLE_EN = 8'h10;
	localparam logic [7:0] ADDR_APPLIED_OFS = 8'h14;
	localparam logic [7:0] ADDR_GAIN_EN = 8'h18;
	localparam logic [7:0] ADDR_ERR_POP = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_INSTR_RESET = 8'h24;
	localparam logic [7:0] ADDR_BW_MHZ = 8'h28;

	typedef enum logic [1:0] {
		SSCC_BW_LOW = 2'b00,
		SSCC_BW_MED = 2'b01,
		SSCC_BW_HIGH = 2'b10,
		SSCC_BW_OFF = 2'b11
	} sscc_bw_t;

	typedef enum logic [1:0] {
		SSCC_MT_AVER = 2'b00,
		SSCC_MT_PEAK = 2'b01,
		SSCC_MT_PEAK_TO_MEAN_TYPE_MEAN = 2'b10,
		SSCC_MT_MIN = 2'b11
	} sscc_mtype_t;

	localparam logic [7:0] BW_LOW_MHZ = 8'h05;
	localparam logic [7:0] BW_MED_MHZ = 8'h0F;
	localparam logic [7:0] BW_HIGH_MHZ = 8'h1E;

	localparam logic [12:0] BUF_SIZE_MIN = 13'h0001;
	localparam logic [12:0] BUF_SIZE_MAX = 13'h1000;
	localparam logic [12:0] BUF_SIZE_RESET = 13'h0001;

	// error codes as positive magnitudes of the negative numbers
	localparam logic [8:0] ERR_NONE = 9'h000;
	localparam logic [8:0] ERR_CONFLICT = 9'h0DD;
	localparam logic [8:0] ERR_RANGE = 9'h0DE;
	localparam logic [8:0] ERR_ILLEGAL = 9'h0E0;
	localparam logic [8:0] ERR_LIST_LEN = 9'h0E2;
	localparam logic [8:0] ERR_NOT_FOUND = 9'h100;

	localparam int TABLE_SEL_VALID_BIT = 8;
	localparam int TABLE_SEL_MALFORMED_BIT = 9;

	typedef struct packed {
		logic avg_detector;
		logic ext_trigger;
		logic fast_rate;
		logic [12:0] sweep_step;
	} sscc_env_t;

	typedef struct packed {
		logic exists;
		logic counts_match;
	} sscc_tbl_info_t;
endpackage : sscc_pkg

// >>> sscc_err_fifo.sv
// sscc_err_fifo: small first-in first-out queue of reported error codes.
// assumes: one push and one pop at most per cycle, same clock as the writer.
`timescale 1ns/100ps
module sscc_err_fifo import sscc_pkg::*; #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// push side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	// pop side
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic empty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire do_push = push && !full;
	wire do_pop = pop && !empty;
	// queue drops new errors when full; oldest are kept so order is never scrambled
	assign empty = (cnt_reg == '0);
	assign full = (cnt_reg == (AW+1)'(DEPTH));
	assign head = mem[rd_reg];
	always_ff @(posedge aclk) begin
		if (do_push) begin
			mem[wr_reg] <= push_data;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (do_pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : sscc_err_fifo

// >>> sscc_top.sv
// sscc_top: sense settings store and command checker behind an AXI4-Lite slave.
// assumes: environment state (detector, trigger, rate, sweep step, table info) arrives
// as same-clock levels from the instrument core.
`timescale 1ns/100ps
module sscc_top import sscc_pkg::*; #(
	parameter int ERR_DEPTH = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// instrument state
	input wire sscc_env_t env,
	input wire sscc_tbl_info_t tbl_info,
	input wire logic [15:0] table_offset_at_freq,
	// settings out
	output logic fir_enable,
	output logic [7:0] video_bw_mhz,
	output logic [12:0] buffered_size,
	output logic [1:0] buffered_measure_type,
	output logic [7:0] offset_table_select,
	output logic offset_table_enable,
	output logic [15:0] applied_freq_offset,
	output logic channel_gain_offset
);
	function automatic logic [7:0] bw_to_mhz(input logic [1:0] sel);
		case (sel)
			SSCC_BW_LOW: bw_to_mhz = BW_LOW_MHZ;
			SSCC_BW_MED: bw_to_mhz = BW_MED_MHZ;
			default: bw_to_mhz = BW_HIGH_MHZ;
		endcase
	endfunction : bw_to_mhz

	// write channel capture: address and data may arrive in either order
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// settings
	logic [1:0] bw_reg;
	logic [12:0] size_reg;
	logic [1:0] mtype_reg;
	logic [7:0] tsel_reg;
	logic tsel_valid_reg;
	logic ten_reg;
	logic gain_reg;
	logic [15:0] ofs_reg;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	wire [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_reg;
	wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_reg;
	wire wr_fire = (aw_have_reg || aw_take) && (w_have_reg || w_take) && !bvalid_reg;
	wire wr_lo = wr_strb[0];

	// per-register write decode
	wire wr_bw = wr_fire && wr_lo && (wr_addr == ADDR_BW);
	wire wr_size = wr_fire && wr_lo && (wr_addr == ADDR_BUF_SIZE);
	wire wr_mtype = wr_fire && wr_lo && (wr_addr == ADDR_MTYPE);
	wire wr_tsel = wr_fire && (wr_addr == ADDR_TABLE_SEL);
	wire wr_ten = wr_fire && wr_lo && (wr_addr == ADDR_TABLE_EN);
	wire wr_gain = wr_fire && wr_lo && (wr_addr == ADDR_GAIN_EN);
	wire wr_ireset = wr_fire && wr_lo && (wr_addr == ADDR_INSTR_RESET) && wr_data[0];
	wire wr_mapped = (wr_addr == ADDR_BW) || (wr_addr == ADDR_BUF_SIZE) ||
		(wr_addr == ADDR_MTYPE) || (wr_addr == ADDR_TABLE_SEL) ||
		(wr_addr == ADDR_TABLE_EN) || (wr_addr == ADDR_GAIN_EN) ||
		(wr_addr == ADDR_INSTR_RESET);

	// checks on each command
	wire bw_conflict = env.avg_detector;
	wire size_step = (env.sweep_step != '0);
	wire size_conflict = !env.ext_trigger || size_step;
	wire size_low = (wr_data[31:0] < 32'(BUF_SIZE_MIN));
	wire size_high = (wr_data[31:0] > 32'(BUF_SIZE_MAX));
	wire [12:0] size_clip = size_low ? BUF_SIZE_MIN :
		size_high ? BUF_SIZE_MAX : wr_data[12:0];
	wire mtype_conflict = !env.ext_trigger || env.avg_detector;
	wire mtype_bad = (wr_data[31:2] != '0);
	wire tsel_malformed = wr_data[TABLE_SEL_MALFORMED_BIT];
	wire tsel_clear = !wr_data[TABLE_SEL_VALID_BIT];
	wire tsel_missing = !tbl_info.exists;
	wire tsel_mismatch = !tbl_info.counts_match;
	wire tsel_ok = !tsel_malformed && !tsel_clear && !tsel_missing && !tsel_mismatch;
	wire ten_conflict = wr_data[0] && !tsel_valid_reg;
	wire gain_conflict = wr_data[0] && env.fast_rate;

	// error picked for this command; malformed name is judged before lookup
	logic [8:0] err_code;
	always_comb begin
		err_code = ERR_NONE;
		if (wr_bw && bw_conflict) err_code = ERR_CONFLICT;
		if (wr_size && size_conflict) err_code = ERR_CONFLICT;
		else if (wr_size && (size_low || size_high)) err_code = ERR_RANGE;
		if (wr_mtype && mtype_bad) err_code = ERR_ILLEGAL;
		else if (wr_mtype && mtype_conflict) err_code = ERR_CONFLICT;
		if (wr_tsel && tsel_malformed) err_code = ERR_ILLEGAL;
		else if (wr_tsel && !tsel_clear && tsel_missing) err_code = ERR_NOT_FOUND;
		else if (wr_tsel && !tsel_clear && tsel_mismatch) err_code = ERR_LIST_LEN;
		if (wr_ten && ten_conflict) err_code = ERR_CONFLICT;
		if (wr_gain && gain_conflict) err_code = ERR_CONFLICT;
	end

	// read decode
	wire rd_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !rvalid_reg;
	wire err_empty;
	wire err_full;
	wire [8:0] err_head;
	wire err_pop = rd_take && (s_axi_araddr == ADDR_ERR_POP);
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_BW: rd_mux = {30'h0, bw_reg};
			ADDR_BW_MHZ: rd_mux = {24'h0, bw_to_mhz(bw_reg)};
			ADDR_BUF_SIZE: rd_mux = {19'h0, size_reg};
			ADDR_MTYPE: rd_mux = {30'h0, mtype_reg};
			// empty name reads as zero with the valid bit clear
			ADDR_TABLE_SEL: rd_mux = {23'h0, tsel_valid_reg,
				tsel_valid_reg ? tsel_reg : 8'h00};
			ADDR_TABLE_EN: rd_mux = {31'h0, ten_reg};
			ADDR_APPLIED_OFS: rd_mux = {16'h0, ofs_reg};
			ADDR_GAIN_EN: rd_mux = {31'h0, gain_reg};
			ADDR_ERR_POP: rd_mux = {err_empty, 22'h0, err_empty ? 9'h000 : err_head};
			ADDR_STATUS: rd_mux = {29'h0, err_full, !err_empty, fir_enable};
			default: rd_hit = 1'b0;
		endcase
	end

	sscc_err_fifo #(
		.WIDTH(9),
		.DEPTH(ERR_DEPTH)
	) sscc_err_fifo_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(err_code != ERR_NONE),
		.push_data(err_code),
		.pop(err_pop),
		.head(err_head),
		.empty(err_empty),
		.full(err_full)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
		end else begin
			if (aw_take) aw_addr_reg <= s_axi_awaddr;
			if (w_take) w_data_reg <= s_axi_wdata;
			if (w_take) w_strb_reg <= s_axi_wstrb;
			aw_have_reg <= wr_fire ? 1'b0 : (aw_have_reg || aw_take);
			w_have_reg <= wr_fire ? 1'b0 : (w_have_reg || w_take);
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'b00;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// instrument reset restores defaults but leaves the table state alone
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_ireset) begin
			bw_reg <= SSCC_BW_OFF;
			size_reg <= BUF_SIZE_RESET;
			mtype_reg <= SSCC_MT_AVER;
			gain_reg <= 1'b0;
		end else begin
			// a bandwidth conflict still stores the value, as the instrument does; size, type and gain conflicts leave the setting
			if (wr_bw) bw_reg <= wr_data[1:0];
			if (size_step) size_reg <= env.sweep_step;
			else if (wr_size && env.ext_trigger) size_reg <= size_clip;
			if (wr_mtype && !mtype_bad && !mtype_conflict) mtype_reg <= wr_data[1:0];
			if (wr_gain && !gain_conflict) gain_reg <= wr_data[0];
		end
	end

	// table state survives instrument reset; bus reset clears it; a select write with valid and malformed bits clear drops valid and enable, not the name
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsel_reg <= 8'h00;
			tsel_valid_reg <= 1'b0;
			ten_reg <= 1'b0;
			ofs_reg <= 16'h0000;
		end else begin
			if (wr_tsel && tsel_clear && !tsel_malformed) begin
				tsel_valid_reg <= 1'b0;
				ten_reg <= 1'b0;
			end else if (wr_tsel && tsel_ok) begin
				tsel_reg <= wr_data[7:0];
				tsel_valid_reg <= 1'b1;
			end
			if (wr_ten) ten_reg <= wr_data[0] && tsel_valid_reg;
			ofs_reg <= ten_reg ? table_offset_at_freq : 16'h0000;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign fir_enable = (bw_reg != SSCC_BW_OFF);
	assign video_bw_mhz = bw_to_mhz(bw_reg);
	assign buffered_size = size_reg;
	assign buffered_measure_type = mtype_reg;
	assign offset_table_select = tsel_reg;
	assign offset_table_enable = ten_reg;
	assign applied_freq_offset = ofs_reg;
	assign channel_gain_offset = gain_reg;

	// defaults after bus reset and after instrument reset
	AST_BW_RESET: assert property (@(posedge aclk) $rose(aresetn) |-> bw_reg == SSCC_BW_OFF)
		else $error("bandwidth not off after reset");
	AST_SIZE_RESET: assert property (@(posedge aclk)
		$rose(aresetn) |-> size_reg == BUF_SIZE_RESET)
		else $error("buffered size not one after reset");
	AST_MTYPE_RESET: assert property (@(posedge aclk)
		$rose(aresetn) |-> mtype_reg == SSCC_MT_AVER)
		else $error("measure type not average after reset");
	AST_GAIN_RESET: assert property (@(posedge aclk)
		$rose(aresetn) |-> !gain_reg)
		else $error("gain offset not off after reset");
	AST_IRESET_DEFAULTS: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ireset |=> bw_reg == SSCC_BW_OFF && size_reg == BUF_SIZE_RESET &&
		mtype_reg == SSCC_MT_AVER && !gain_reg)
		else $error("instrument reset left a setting");

	// bandwidth
	AST_FIR: assert property (@(posedge aclk) disable iff (!aresetn)
		fir_enable == (video_bw_mhz != BW_HIGH_MHZ || bw_reg == SSCC_BW_HIGH))
		else $error("fir enable does not match bandwidth");
	AST_BW_CONFLICT: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_bw && env.avg_detector |-> err_code == ERR_CONFLICT)
		else $error("bandwidth conflict not reported");

	// buffered size
	AST_SIZE_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
		size_reg >= BUF_SIZE_MIN && (env.sweep_step != '0 || size_reg <= BUF_SIZE_MAX))
		else $error("buffer size out of range");
	AST_SIZE_CLIP_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_size && env.ext_trigger && env.sweep_step == '0 && wr_data > 32'(BUF_SIZE_MAX)
		|-> err_code == ERR_RANGE ##1 size_reg == BUF_SIZE_MAX)
		else $error("large size not clipped to upper limit");
	AST_SIZE_CLIP_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_size && env.ext_trigger && env.sweep_step == '0 && wr_data < 32'(BUF_SIZE_MIN)
		|-> err_code == ERR_RANGE ##1 size_reg == BUF_SIZE_MIN)
		else $error("small size not clipped to lower limit");
	AST_SIZE_CONFLICT: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_size && !env.ext_trigger |-> err_code == ERR_CONFLICT)
		else $error("size without external trigger not reported");
	AST_SIZE_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		env.sweep_step != '0 && !wr_ireset |=> size_reg == $past(env.sweep_step))
		else $error("sweep step did not override size");
	AST_SIZE_STEP_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_size && env.sweep_step != '0 |-> err_code == ERR_CONFLICT)
		else $error("size write during sweep not reported");

	// measure type
	AST_MTYPE_CONFLICT: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_mtype && wr_data[31:2] == '0 && (!env.ext_trigger || env.avg_detector)
		|-> err_code == ERR_CONFLICT ##1 $stable(mtype_reg))
		else $error("type conflict not refused");
	AST_MTYPE_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_mtype && wr_data[31:2] != '0 |-> ##1 $stable(mtype_reg) && !err_empty)
		else $error("illegal type accepted");

	// offset table
	AST_TSEL_MISSING: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_tsel && !wr_data[TABLE_SEL_MALFORMED_BIT] && wr_data[TABLE_SEL_VALID_BIT] &&
		!tbl_info.exists |-> err_code == ERR_NOT_FOUND)
		else $error("missing table not reported");
	AST_TSEL_MALFORMED: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_tsel && wr_data[TABLE_SEL_MALFORMED_BIT] |-> err_code == ERR_ILLEGAL)
		else $error("malformed table name not reported");
	AST_TSEL_LENGTH: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_tsel && !wr_data[TABLE_SEL_MALFORMED_BIT] && wr_data[TABLE_SEL_VALID_BIT] &&
		tbl_info.exists && !tbl_info.counts_match |-> err_code == ERR_LIST_LEN)
		else $error("point count mismatch not reported");
	AST_IRESET_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ireset && !wr_tsel |=> tsel_valid_reg == $past(tsel_valid_reg))
		else $error("instrument reset touched table");
	AST_TEN_NOTABLE: assert property (@(posedge aclk) disable iff (!aresetn)
		!tsel_valid_reg |=> !ten_reg)
		else $error("table enabled without selection");
	AST_OFS_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn)
		!ten_reg |=> ofs_reg == 16'h0000)
		else $error("offset applied while table disabled");
	AST_OFS_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
		ten_reg |=> ofs_reg == $past(table_offset_at_freq))
		else $error("offset does not follow frequency");

	// channel gain offset and error queue
	AST_GAIN_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_gain && env.fast_rate && !gain_reg && !wr_ireset |=> !gain_reg)
		else $error("gain enabled at fast rate");
	AST_GAIN_ON: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_gain && wr_data[0] && !env.fast_rate |=> gain_reg)
		else $error("gain enable not taken");
	AST_ERR_QUEUED: assert property (@(posedge aclk) disable iff (!aresetn)
		err_code != ERR_NONE |=> !err_empty)
		else $error("reported error not queued");
endmodule : sscc_top

// >>> sscc_core_model.sv
// sscc_core_model: instrument core stand-in for table lookup and offset.
// assumes: the table name id rides on the write data low byte.
`timescale 1ns/100ps
module sscc_core_model import sscc_pkg::*; (
	// lookup request
	input wire logic [31:0] wdata,
	input wire logic [7:0] sel,
	input wire logic [7:0] freq,
	// lookup results
	output sscc_tbl_info_t info,
	output logic [15:0] ofs
);
	// ids F0..FF are absent; id 33 has a short offset list
	assign info.exists = wdata[7:4] != 4'hF;
	assign info.counts_match = wdata[7:0] != 8'h33;
	// offset tracks frequency so a stale value is visible
	assign ofs = {freq, sel};
endmodule : sscc_core_model

// >>> sensor_setting_command_checker_test.sv
// sensor_setting_command_checker_test: self-checking bench for sscc_top.
// assumes: core model answers table lookups; bench drives env levels.
`timescale 1ns/100ps
module sensor_setting_command_checker_test import sscc_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, freq = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, fir_en, tbl_en, gain_en;
	logic [1:0] bresp, rresp, mtype, r;
	logic [7:0] bw_mhz, tbl_sel;
	logic [12:0] size;
	logic [15:0] tofs, aofs;
	sscc_env_t env = '0;
	sscc_tbl_info_t info;
	int miscompares = 0, tests_run = 0;
	always #2 aclk = ~aclk;
	sscc_top sscc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .env(env), .tbl_info(info), .table_offset_at_freq(tofs),
		.fir_enable(fir_en), .video_bw_mhz(bw_mhz), .buffered_size(size),
		.buffered_measure_type(mtype), .offset_table_select(tbl_sel),
		.offset_table_enable(tbl_en), .applied_freq_offset(aofs),
		.channel_gain_offset(gain_en));
	sscc_core_model sscc_core_model_i (.wdata(wdata), .sel(tbl_sel), .freq(freq),
		.info(info), .ofs(tofs));
	task automatic check(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic finish_test;
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		bit got;
		got = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid === 1'h1) begin
				got = 1;
				resp = bresp;
				bready <= 1'h0;
			end
		end
		if (!got)
			check("write timeout", 32'h1, 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		bit got;
		got = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid === 1'h1) begin
				got = 1;
				d = rdata;
				resp = rresp;
				rready <= 1'h0;
			end
		end
		if (!got)
			check("read timeout", 32'h1, 32'h0);
	endtask : rd
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] x;
		wr(a, d, x);
	endtask : w
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] x;
		rd(a, d, x);
		check(what, exp, d);
	endtask : rc
	task automatic err(input logic [8:0] code);
		rc("error queue", ADDR_ERR_POP, {23'h0, code});
	endtask : err
	task automatic t_reset;
		rc("bandwidth", ADDR_BW, 32'h3);
		rc("size", ADDR_BUF_SIZE, 32'h1);
		rc("type", ADDR_MTYPE, 32'h0);
		rc("gain", ADDR_GAIN_EN, 32'h0);
		check("fir", 32'h0, fir_en);
		rc("status", ADDR_STATUS, 32'h0);
		check("table select out", 32'h0, tbl_sel);
		check("table enable out", 32'h0, tbl_en);
		rc("queue empty", ADDR_ERR_POP, 32'h8000_0000);
	endtask : t_reset
	task automatic t_bw;
		logic [7:0] mhz[4] = '{8'h05, 8'h0F, 8'h1E, 8'h1E};
		for (int i = 0; i < 4; i++) begin
			w(ADDR_BW, i);
			check("mhz", mhz[i], bw_mhz);
			rc("mhz reg", ADDR_BW_MHZ, mhz[i]);
			check("fir", i != 3, fir_en);
		end
		@(posedge aclk) env.avg_detector <= 1'h1;
		w(ADDR_BW, 1);
		err(ERR_CONFLICT);
		@(posedge aclk) env.avg_detector <= 1'h0;
	endtask : t_bw
	task automatic t_size;
		@(posedge aclk) env.ext_trigger <= 1'h1;
		w(ADDR_BUF_SIZE, 0);
		err(ERR_RANGE);
		rc("size low", ADDR_BUF_SIZE, 32'h1);
		w(ADDR_BUF_SIZE, 32'h1388);
		err(ERR_RANGE);
		check("size high", 13'h1000, size);
		w(ADDR_BUF_SIZE, 32'h1000);
		rc("queue empty", ADDR_ERR_POP, 32'h8000_0000);
		w(ADDR_BUF_SIZE, 32'hA);
		@(posedge aclk) env.ext_trigger <= 1'h0;
		w(ADDR_BUF_SIZE, 32'h14);
		err(ERR_CONFLICT);
		rc("size kept", ADDR_BUF_SIZE, 32'hA);
		@(posedge aclk) env <= '{1'h0, 1'h1, 1'h0, 13'h7};
		repeat (3) @(posedge aclk);
		check("size step", 13'h7, size);
		w(ADDR_BUF_SIZE, 32'h14);
		err(ERR_CONFLICT);
		rc("size step", ADDR_BUF_SIZE, 32'h7);
		@(posedge aclk) env.sweep_step <= 13'h0;
	endtask : t_size
	task automatic t_mtype;
		for (int i = 0; i < 4; i++) begin
			w(ADDR_MTYPE, i);
			check("type", i, mtype);
		end
		w(ADDR_MTYPE, 32'h4);
		@(posedge aclk) env.avg_detector <= 1'h1;
		w(ADDR_MTYPE, 32'h1);
		@(posedge aclk) env <= '0;
		w(ADDR_MTYPE, 32'h2);
		err(ERR_ILLEGAL);
		err(ERR_CONFLICT);
		err(ERR_CONFLICT);
		rc("type kept", ADDR_MTYPE, 32'h3);
		@(posedge aclk) env.ext_trigger <= 1'h1;
	endtask : t_mtype
	task automatic t_table;
		w(ADDR_TABLE_EN, 1);
		err(ERR_CONFLICT);
		rc("enable", ADDR_TABLE_EN, 32'h0);
		rc("no table", ADDR_TABLE_SEL, 32'h0);
		w(ADDR_TABLE_SEL, 32'h1F5);
		err(ERR_NOT_FOUND);
		w(ADDR_TABLE_SEL, 32'h322);
		err(ERR_ILLEGAL);
		w(ADDR_TABLE_SEL, 32'h133);
		err(ERR_LIST_LEN);
		rc("no table", ADDR_TABLE_SEL, 32'h0);
		freq <= 8'h44;
		w(ADDR_TABLE_SEL, 32'h122);
		rc("table", ADDR_TABLE_SEL, 32'h122);
		check("select out", 32'h22, tbl_sel);
		rc("offset off", ADDR_APPLIED_OFS, 32'h0);
		w(ADDR_TABLE_EN, 1);
		rc("enable", ADDR_TABLE_EN, 32'h1);
		check("enable out", 32'h1, tbl_en);
		rc("offset", ADDR_APPLIED_OFS, 32'h4422);
		@(posedge aclk) freq <= 8'h55;
		rc("offset freq", ADDR_APPLIED_OFS, 32'h5522);
		wr(ADDR_APPLIED_OFS, 32'h1234, r);
		check("offset ro resp", 2'h2, r);
		rc("offset ro", ADDR_APPLIED_OFS, 32'h5522);
		w(ADDR_INSTR_RESET, 1);
		rc("enable kept", ADDR_TABLE_EN, 32'h1);
		rc("table kept", ADDR_TABLE_SEL, 32'h122);
		check("offset kept", 16'h5522, aofs);
		w(ADDR_TABLE_EN, 0);
		rc("disabled", ADDR_TABLE_EN, 32'h0);
		check("enable out off", 32'h0, tbl_en);
		rc("offset off", ADDR_APPLIED_OFS, 32'h0);
		w(ADDR_TABLE_SEL, 32'h0);
		rc("deselect", ADDR_TABLE_SEL, 32'h0);
	endtask : t_table
	task automatic t_gain;
		logic [31:0] d;
		@(posedge aclk) env.fast_rate <= 1'h1;
		w(ADDR_GAIN_EN, 1);
		rc("status pending", ADDR_STATUS, 32'h2);
		err(ERR_CONFLICT);
		rc("gain", ADDR_GAIN_EN, 32'h0);
		// one more than the queue holds; the last one is dropped
		for (int i = 0; i < 9; i++) begin
			w(ADDR_GAIN_EN, 1);
		end
		rc("status full", ADDR_STATUS, 32'h6);
		for (int i = 0; i < 8; i++) begin
			err(ERR_CONFLICT);
		end
		rc("queue drained", ADDR_ERR_POP, 32'h8000_0000);
		@(posedge aclk) env.fast_rate <= 1'h0;
		w(ADDR_GAIN_EN, 1);
		check("gain on", 1'h1, gain_en);
		w(ADDR_BW, 2);
		w(ADDR_INSTR_RESET, 1);
		check("gain reset", 1'h0, gain_en);
		rc("bw reset", ADDR_BW, 32'h3);
		check("size reset", 13'h1, size);
		check("type reset", 2'h0, mtype);
		wr(8'h3C, 32'h1, r);
		check("bresp", 2'h2, r);
		rd(8'h3C, d, r);
		check("rresp", 2'h2, r);
	endtask : t_gain
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_bw();
		t_size();
		t_mtype();
		t_table();
		t_gain();
		finish_test();
	end
	// whole run is a few hundred cycles; the 25000-cycle limit leaves wide margin
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
endmodule : sensor_setting_command_checker_test
